// file: core/cisr_alu.sv
`timescale 1ns/100ps
`default_nettype none

module cisr_alu
(
  // Operation select
  input wire logic rotate,
  // Operands
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  input wire logic carry_in,
  // Results
  output logic [7:0] result,
  output logic carry_out,
  output logic digit_carry_out,
  output logic zero_out
);

  // ==========================================================================
  // Two's complement subtraction, minuend minus subtrahend
  function automatic logic [8:0] sub_nbits(input logic [7:0] a, input logic [7:0] b);
    sub_nbits = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction

  logic [8:0] diff;
  logic [8:0] low_diff;

  always_comb
  begin
    diff = sub_nbits(opnd_a, opnd_b);
    low_diff = sub_nbits({4'h0, opnd_a[3:0]}, {4'h0, opnd_b[3:0]});
    if (rotate)
    begin
      result = {carry_in, opnd_a[7:1]};
      carry_out = opnd_a[0];
    end
    else
    begin
      result = diff[7:0];
      carry_out = diff[8];
    end
    // Zero-extended nibbles: bit 8 set means no borrow out of bit 3
    digit_carry_out = low_diff[8];
    zero_out = (result == 8'h00);
  end

endmodule // cisr_alu

`default_nettype wire

// file: core/cisr_core.sv
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

module cisr_core
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Core state
  output logic SLEEP_ACTIVE,
  output logic BUSY
);

  // ==========================================================================
  // State
  typedef struct packed {
    cisr_pkg::cisr_state_type state;
    logic [11:0] instr;
    logic [7:0] accum;
    logic [4:0] status;
    logic [12:0] pc;
    logic [7:0][12:0] stack;
    logic [2:0] sp;
    logic [127:0][7:0] file;
    logic [6:0] faddr;
    logic [7:0] watchdog_counter;
    logic [7:0] prescale;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic asleep;
    logic in_tail;
  } cisr_core_type;

  cisr_core_type core_r;
  cisr_core_type core_nxt;

  // ==========================================================================
  // Address decode
  function automatic logic addr_known(input logic [7:0] addr);
    addr_known = (addr == cisr_pkg::OFS_INSTR) || (addr == cisr_pkg::OFS_ACCUM) ||
      (addr == cisr_pkg::OFS_STATUS) || (addr == cisr_pkg::OFS_PC) ||
      (addr == cisr_pkg::OFS_STACK) || (addr == cisr_pkg::OFS_FILE_ADDR) ||
      (addr == cisr_pkg::OFS_FILE_DATA) || (addr == cisr_pkg::OFS_CORE) ||
      (addr == cisr_pkg::OFS_WAKE);
  endfunction

  // ==========================================================================
  // State decode and stack top
  function automatic logic is_asleep(input cisr_pkg::cisr_state_type s);
    is_asleep = (s == cisr_pkg::ST_SLEEP);
  endfunction

  function automatic logic is_tail(input cisr_pkg::cisr_state_type s);
    is_tail = (s == cisr_pkg::ST_RETURN_TAIL);
  endfunction

  function automatic logic [12:0] stack_top(input logic [7:0][12:0] stk, input logic [2:0] sp);
    stack_top = stk[sp - cisr_pkg::SP_STEP];
  endfunction

  // ==========================================================================
  // Instruction fields from the write data being committed
  logic [2:0] opc;
  logic dest_file;
  logic [7:0] literal;
  logic [6:0] op_faddr;
  logic [7:0] file_val;
  logic [7:0] alu_a;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic is_rotate;

  assign opc = PWDATA[cisr_pkg::OPC_LSB +: cisr_pkg::OPC_W];
  assign dest_file = PWDATA[cisr_pkg::DEST_BIT];
  assign literal = PWDATA[cisr_pkg::ARG_LSB +: cisr_pkg::LIT_W];
  assign op_faddr = PWDATA[cisr_pkg::ARG_LSB +: cisr_pkg::FADDR_W];
  assign file_val = core_r.file[op_faddr];
  assign is_rotate = (opc == cisr_pkg::OPC_ROTATE_RIGHT);
  assign alu_a = (opc == cisr_pkg::OPC_SUB_LITERAL) ? literal : file_val;

  cisr_alu u_alu
  (
    .rotate(is_rotate),
    .opnd_a(alu_a),
    .opnd_b(core_r.accum),
    .carry_in(core_r.status[cisr_pkg::ST_CARRY_BIT]),
    .result(alu_res),
    .carry_out(alu_c),
    .digit_carry_out(alu_dc),
    .zero_out(alu_z)
  );

  // ==========================================================================
  // Next state
  logic access;
  logic commit;
  logic wr;
  logic [2:0] sp_dec;

  always_comb
  begin
    core_nxt = core_r;
    access = PSEL & PENABLE;
    commit = access & core_r.pready;
    wr = commit & PWRITE & addr_known(PADDR);
    sp_dec = core_r.sp - cisr_pkg::SP_STEP;

    // ======================================================================
    // APB answer one cycle into the access phase, held off by a return tail
    core_nxt.pready = access & ~core_r.pready & ~is_tail(core_r.state);
    core_nxt.pslverr = 1'b0;
    core_nxt.prdata = 32'h0000_0000;
    if (core_nxt.pready)
    begin
      core_nxt.pslverr = ~addr_known(PADDR) |
        (PWRITE & (PADDR == cisr_pkg::OFS_INSTR) & is_asleep(core_r.state));
      if (!PWRITE)
      begin
        unique case (PADDR)
          cisr_pkg::OFS_INSTR: core_nxt.prdata = {20'h00000, core_r.instr};
          cisr_pkg::OFS_ACCUM: core_nxt.prdata = {24'h000000, core_r.accum};
          cisr_pkg::OFS_STATUS: core_nxt.prdata = {27'h0000000, core_r.status};
          cisr_pkg::OFS_PC: core_nxt.prdata = {19'h00000, core_r.pc};
          cisr_pkg::OFS_STACK: core_nxt.prdata = {19'h00000, stack_top(core_r.stack, core_r.sp)};
          cisr_pkg::OFS_FILE_ADDR: core_nxt.prdata = {25'h0000000, core_r.faddr};
          cisr_pkg::OFS_FILE_DATA: core_nxt.prdata = {24'h000000, core_r.file[core_r.faddr]};
          cisr_pkg::OFS_CORE:
          begin
            core_nxt.prdata[cisr_pkg::CORE_ASLEEP_BIT] = is_asleep(core_r.state);
            core_nxt.prdata[cisr_pkg::CORE_BUSY_BIT] = is_tail(core_r.state);
            core_nxt.prdata[cisr_pkg::CORE_SP_LSB +: cisr_pkg::SP_W] = core_r.sp;
            core_nxt.prdata[cisr_pkg::CORE_WATCHDOG_LSB +: 8] = core_r.watchdog_counter;
            core_nxt.prdata[cisr_pkg::CORE_PRE_LSB +: 8] = core_r.prescale;
          end
          default: core_nxt.prdata = 32'h0000_0000;
        endcase
      end
    end

    // ======================================================================
    // Watchdog runs only while the oscillator runs
    if (!is_asleep(core_r.state))
    begin
      core_nxt.prescale = core_r.prescale + cisr_pkg::CNT_STEP;
      if (core_r.prescale == cisr_pkg::PRE_LAST)
      begin
        core_nxt.watchdog_counter = core_r.watchdog_counter + cisr_pkg::CNT_STEP;
      end
    end

    // ======================================================================
    // Second cycle of a return is a flushed slot
    if (is_tail(core_r.state))
    begin
      core_nxt.state = cisr_pkg::ST_RUN;
    end

    // ======================================================================
    // Software register writes
    if (wr)
    begin
      unique case (PADDR)
        cisr_pkg::OFS_ACCUM: core_nxt.accum = PWDATA[7:0];
        cisr_pkg::OFS_STATUS: core_nxt.status = PWDATA[cisr_pkg::STATUS_W-1:0];
        cisr_pkg::OFS_PC: core_nxt.pc = PWDATA[cisr_pkg::PC_W-1:0];
        cisr_pkg::OFS_STACK:
        begin
          core_nxt.stack[core_r.sp] = PWDATA[cisr_pkg::PC_W-1:0];
          core_nxt.sp = core_r.sp + cisr_pkg::SP_STEP;
        end
        cisr_pkg::OFS_FILE_ADDR: core_nxt.faddr = PWDATA[cisr_pkg::FADDR_W-1:0];
        cisr_pkg::OFS_FILE_DATA: core_nxt.file[core_r.faddr] = PWDATA[7:0];
        cisr_pkg::OFS_WAKE:
        begin
          if (PWDATA[cisr_pkg::WAKE_BIT] && is_asleep(core_r.state))
          begin
            core_nxt.state = cisr_pkg::ST_RUN;
          end
        end
        default:
        begin
        end
      endcase
    end

    // ======================================================================
    // Instruction issue; ignored while asleep
    if (wr && PADDR == cisr_pkg::OFS_INSTR && core_r.state == cisr_pkg::ST_RUN)
    begin
      core_nxt.instr = PWDATA[cisr_pkg::INSTR_W-1:0];
      core_nxt.pc = core_r.pc + cisr_pkg::PC_STEP;
      unique case (opc)
        cisr_pkg::OPC_SLEEP:
        begin
          core_nxt.status[cisr_pkg::ST_POWER_DOWN_BIT] = 1'b0;
          core_nxt.status[cisr_pkg::ST_TIME_OUT_BIT] = 1'b1;
          core_nxt.watchdog_counter = cisr_pkg::WATCHDOG_CLEAR;
          core_nxt.prescale = cisr_pkg::PRE_CLEAR;
          core_nxt.state = cisr_pkg::ST_SLEEP;
        end
        cisr_pkg::OPC_RETURN:
        begin
          core_nxt.sp = sp_dec;
          core_nxt.pc = stack_top(core_r.stack, core_r.sp);
          core_nxt.state = cisr_pkg::ST_RETURN_TAIL;
        end
        cisr_pkg::OPC_ROTATE_RIGHT:
        begin
          core_nxt.status[cisr_pkg::ST_CARRY_BIT] = alu_c;
          if (dest_file)
          begin
            core_nxt.file[op_faddr] = alu_res;
          end
          else
          begin
            core_nxt.accum = alu_res;
          end
        end
        cisr_pkg::OPC_SUB_LITERAL:
        begin
          core_nxt.accum = alu_res;
          core_nxt.status[cisr_pkg::ST_CARRY_BIT] = alu_c;
          core_nxt.status[cisr_pkg::ST_DIGIT_CARRY_BIT] = alu_dc;
          core_nxt.status[cisr_pkg::ST_ZERO_BIT] = alu_z;
        end
        cisr_pkg::OPC_SUB_FILE:
        begin
          core_nxt.status[cisr_pkg::ST_CARRY_BIT] = alu_c;
          core_nxt.status[cisr_pkg::ST_DIGIT_CARRY_BIT] = alu_dc;
          core_nxt.status[cisr_pkg::ST_ZERO_BIT] = alu_z;
          if (dest_file)
          begin
            core_nxt.file[op_faddr] = alu_res;
          end
          else
          begin
            core_nxt.accum = alu_res;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Status outputs follow the next state so they leave flops
    core_nxt.asleep = is_asleep(core_nxt.state);
    core_nxt.in_tail = is_tail(core_nxt.state);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CLK_SYS)
  begin
    if (!RSTN)
    begin
      core_r <= '0;
      core_r.state <= cisr_pkg::ST_RUN;
      core_r.instr <= cisr_pkg::INSTR_RST;
      core_r.status <= cisr_pkg::STATUS_RST;
      core_r.pc <= cisr_pkg::PC_RST;
    end
    else
    begin
      core_r <= core_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign PRDATA = core_r.prdata;
  assign PREADY = core_r.pready;
  assign PSLVERR = core_r.pslverr;
  assign SLEEP_ACTIVE = core_r.asleep;
  assign BUSY = core_r.in_tail;

endmodule // cisr_core

`default_nettype wire

// file: inc/cisr_pkg.sv
package cisr_pkg;

  // ==========================================================================
  // Clock
  localparam int unsigned CLK_HZ = 25_000_000;

  // ==========================================================================
  // APB register map, byte addresses
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACCUM = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_STACK = 8'h10;
  localparam logic [7:0] OFS_FILE_ADDR = 8'h14;
  localparam logic [7:0] OFS_FILE_DATA = 8'h18;
  localparam logic [7:0] OFS_CORE = 8'h1c;
  localparam logic [7:0] OFS_WAKE = 8'h20;

  // ==========================================================================
  // Instruction word fields
  localparam int unsigned INSTR_W = 12;
  localparam int unsigned ARG_LSB = 0;
  localparam int unsigned LIT_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned OPC_W = 3;
  localparam int unsigned DEST_BIT = 11;
  localparam logic [11:0] INSTR_RST = 12'h000;

  typedef enum logic [2:0] {
    OPC_SLEEP = 3'h0,
    OPC_RETURN = 3'h1,
    OPC_ROTATE_RIGHT = 3'h2,
    OPC_SUB_LITERAL = 3'h3,
    OPC_SUB_FILE = 3'h4
  } cisr_opc_type;

  // ==========================================================================
  // Status register bits and reset value
  localparam int unsigned ST_CARRY_BIT = 0;
  localparam int unsigned ST_DIGIT_CARRY_BIT = 1;
  localparam int unsigned ST_ZERO_BIT = 2;
  localparam int unsigned ST_POWER_DOWN_BIT = 3;
  localparam int unsigned ST_TIME_OUT_BIT = 4;
  localparam int unsigned STATUS_W = 5;
  localparam logic [4:0] STATUS_RST = 5'h18;

  // ==========================================================================
  // Core state register fields
  localparam int unsigned CORE_ASLEEP_BIT = 0;
  localparam int unsigned CORE_BUSY_BIT = 1;
  localparam int unsigned CORE_SP_LSB = 4;
  localparam int unsigned CORE_WATCHDOG_LSB = 8;
  localparam int unsigned CORE_PRE_LSB = 16;
  localparam int unsigned WAKE_BIT = 0;

  // ==========================================================================
  // Sizes and reset values
  localparam int unsigned PC_W = 13;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SP_W = 3;
  localparam logic [2:0] SP_STEP = 3'h1;
  localparam int unsigned FILE_DEPTH = 128;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRE_CLEAR = 8'h00;
  localparam logic [7:0] PRE_LAST = 8'hff;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // ==========================================================================
  // Core states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_RETURN_TAIL = 3'b010,
    ST_SLEEP = 3'b100
  } cisr_state_type;

endpackage

// file: verif/cisr_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module cisr_chk
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Core state
  input wire logic SLEEP_ACTIVE,
  input wire logic BUSY
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  logic done;
  logic iw;
  assign done = PSEL && PENABLE && PREADY;
  assign iw = done && PWRITE && PADDR == cisr_pkg::OFS_INSTR;

  // ==========================================================================
  // Sleep and return
  property p_sleep_enter;
    iw && !SLEEP_ACTIVE && PWDATA[10:8] == 3'h0 |=> SLEEP_ACTIVE;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("sleep instruction did not halt the core");
  property p_sleep_hold;
    SLEEP_ACTIVE && !(done && PWRITE && PADDR == cisr_pkg::OFS_WAKE && PWDATA[0])
      |=> SLEEP_ACTIVE;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("core left sleep without a wake write");
  property p_refuse;
    iw && SLEEP_ACTIVE |-> PSLVERR;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("instruction accepted while asleep");
  property p_ret_busy;
    iw && !SLEEP_ACTIVE && PWDATA[10:8] == 3'h1 |=> BUSY ##1 !BUSY;
  endproperty
  a_ret_busy: assert property (p_ret_busy)
    else $error("return did not take two cycles");
  property p_busy_cause;
    $rose(BUSY) |-> $past(iw) && $past(PWDATA[10:8]) == 3'h1;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without a return");

  // ==========================================================================
  // Bus
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  property p_ready_bound;
    $rose(PENABLE) && PSEL |-> ##[1:2] PREADY;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("ready late");
  property p_idle_data;
    !PREADY |-> PRDATA == 32'h0 && !PSLVERR;
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("read data or error outside ready");
  property p_unmapped;
    PREADY && PADDR > cisr_pkg::OFS_WAKE |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address without error");
endmodule // cisr_chk

bind cisr_core cisr_chk u_cisr_chk
(
  .CLK_SYS, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .SLEEP_ACTIVE, .BUSY
);

`default_nettype wire

// file: verif/tb_cisr_core.sv
`timescale 1ns/100ps
`default_nettype none

module tb_cisr_core;
  logic CLK_SYS = 1'h0;
  logic RSTN = 1'h0;
  logic PSEL = 1'h0;
  logic PENABLE = 1'h0;
  logic PWRITE = 1'h0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic SLEEP_ACTIVE;
  logic BUSY;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e;

  cisr_core u_cisr_core
  (
    .CLK_SYS, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .SLEEP_ACTIVE, .BUSY
  );

  always #20 CLK_SYS = ~CLK_SYS;

  // ==========================================================================
  // Tasks
  task automatic results();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'h1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'h1)
      @(posedge CLK_SYS);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'h0, a, 32'h0);
    chk(q, x);
  endtask

  // Accumulator a, file register 0x7f holds b
  task automatic load(input logic [7:0] a, input logic [7:0] b);
    wr(cisr_pkg::OFS_ACCUM, {24'h0, a});
    wr(cisr_pkg::OFS_FILE_ADDR, 32'h7f);
    wr(cisr_pkg::OFS_FILE_DATA, {24'h0, b});
  endtask

  task automatic sub(input logic f, input logic d, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = b - a;
    load(a, b);
    wr(cisr_pkg::OFS_INSTR, {20'h0, d, f ? 3'h4 : 3'h3, f ? 8'h7f : b});
    rd(cisr_pkg::OFS_ACCUM, {24'h0, f && d ? a : r});
    rd(cisr_pkg::OFS_FILE_DATA, {24'h0, f && d ? r : b});
    rd(cisr_pkg::OFS_STATUS, {27'h0, 2'h3, r == 8'h0, b[3:0] >= a[3:0], b >= a});
  endtask

  task automatic rot(input logic c, input logic d, input logic [7:0] b);
    logic [7:0] r;
    r = {c, b[7:1]};
    load(8'h5a, b);
    wr(cisr_pkg::OFS_STATUS, {27'h0, 2'h3, 2'h0, c});
    wr(cisr_pkg::OFS_INSTR, {20'h0, d, 3'h2, 8'h7f});
    rd(cisr_pkg::OFS_ACCUM, {24'h0, d ? 8'h5a : r});
    rd(cisr_pkg::OFS_FILE_DATA, {24'h0, d ? r : b});
    rd(cisr_pkg::OFS_STATUS, {27'h0, 2'h3, 2'h0, b[0]});
  endtask

  // ==========================================================================
  // Sequence
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    repeat (12) @(posedge CLK_SYS);
    RSTN <= 1'h1;
    rd(cisr_pkg::OFS_STATUS, 32'h18);
    sub(1'h0, 1'h0, 8'h05, 8'h03);
    sub(1'h0, 1'h0, 8'h22, 8'h22);
    sub(1'h0, 1'h1, 8'h0f, 8'h10);
    sub(1'h1, 1'h1, 8'h41, 8'h40);
    sub(1'h1, 1'h0, 8'h01, 8'hff);
    sub(1'h1, 1'h1, 8'h00, 8'h00);
    rot(1'h1, 1'h0, 8'h02);
    rot(1'h0, 1'h1, 8'h03);
    rot(1'h1, 1'h1, 8'hff);
    // Two pushes, two returns, flags all set beforehand
    wr(cisr_pkg::OFS_STACK, 32'h123);
    wr(cisr_pkg::OFS_STACK, 32'h0a5);
    wr(cisr_pkg::OFS_PC, 32'h050);
    wr(cisr_pkg::OFS_STATUS, 32'h1f);
    wr(cisr_pkg::OFS_INSTR, 32'h100);
    @(negedge CLK_SYS);
    chk({31'h0, BUSY}, 32'h1);
    rd(cisr_pkg::OFS_PC, 32'h0a5);
    wr(cisr_pkg::OFS_INSTR, 32'h100);
    rd(cisr_pkg::OFS_PC, 32'h123);
    rd(cisr_pkg::OFS_STATUS, 32'h1f);
    xfer(1'h0, cisr_pkg::OFS_CORE, 32'h0);
    chk(q & 32'h73, 32'h0);
    // Sleep with time-out cleared first
    wr(cisr_pkg::OFS_STATUS, 32'h08);
    wr(cisr_pkg::OFS_INSTR, 32'h000);
    rd(cisr_pkg::OFS_STATUS, 32'h10);
    repeat (300) @(posedge CLK_SYS);
    xfer(1'h0, cisr_pkg::OFS_CORE, 32'h0);
    chk(q & 32'hffff03, 32'h1);
    xfer(1'h1, cisr_pkg::OFS_INSTR, 32'h3ff);
    chk({31'h0, e}, 32'h1);
    rd(cisr_pkg::OFS_ACCUM, 32'h5a);
    wr(cisr_pkg::OFS_WAKE, 32'h1);
    @(negedge CLK_SYS);
    chk({31'h0, SLEEP_ACTIVE}, 32'h0);
    xfer(1'h0, 8'h24, 32'h0);
    chk({31'h0, e}, 32'h1);
    results();
  end
endmodule // tb_cisr_core

`default_nettype wire
